// File: common/eeprom_front_pkg.sv
// Types shared by the two-wire EEPROM slave front end.
// Assumes the constants header is compiled alongside.
package eeprom_front_pkg;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_CTRL,
        ST_WADDR,
        ST_WDATA,
        ST_RDATA,
        ST_IGNORE
    } slave_state_t;

    // Every asynchronous pin input, synchronised together into the system clock domain.
    typedef struct packed {
        logic scl;
        logic sda;
        logic [2:0] sel;
        logic wp;
        logic supply_low;
    } pin_in_t;

    typedef logic [7:0] byte_t;

endpackage : eeprom_front_pkg

// File: common/eeprom_front_regs.svh
// Timing counts, field positions and sizes for the two-wire EEPROM slave front end.
// Assumes the includer uses these only as constants; no logic lives here.
`ifndef EEPROM_FRONT_REGS_SVH
`define EEPROM_FRONT_REGS_SVH

// System clock rate and the self-timed write cycle.
`define CLK_FREQ_KHZ 20000
`define WRITE_CYCLE_TIME_US 5000
`define WRITE_CYCLE_COUNT ((`WRITE_CYCLE_TIME_US * `CLK_FREQ_KHZ) / 1000)
`define WRITE_TIMER_W 17

// Bit positions inside one nine-clock byte frame.
`define BIT_LAST 4'h7
`define ACK_SLOT 4'h8

// Control byte fields.
`define CTRL_CODE_MSB 7
`define CTRL_CODE_LSB 4
`define CTRL_SEL_MSB 3
`define CTRL_SEL_LSB 1
`define CTRL_RW_BIT 0

// Array and page sizes.
`define MEM_DEPTH 256
`define PAGE_DEPTH 16

`endif

// File: rtl/eeprom_two_wire_slave_front.sv
// Two-wire serial slave front end of a 256-byte EEPROM, with array and page buffer.
// Assumes an external pull-up on the data wire and a master that makes the serial clock.
`timescale 1ns/1ns
`include "eeprom_front_regs.svh"

// How it works
// [R1] Data line is only pulled low or released, never driven high.
// [R2] Data changes only while serial clock is low, except bus conditions.
// [R3] Master makes the clock and all Start and Stop; device is slave.
// [R4] Both lines high means bus idle; transfers start only from there.
// [R5] Data falling while clock high is Start; every command begins with it.
// [R6] Data rising while clock high is Stop; every operation ends with it.
// [R7] One data bit per clock pulse, sampled at the clock rising edge.
// [R8] Excess write bytes overwrite oldest buffered ones, keeping the last sixteen.
// [R9] Addressed receiver acknowledges each byte on a ninth clock pulse.
// [R10] No acknowledge at all while the internal programming cycle runs.
// [R11] Acknowledger holds data low through the whole ninth clock high phase.
// [R12] Master not acknowledging ends a read; device releases the data line.
// [R13] First byte after Start is control byte; upper four bits are type code.
// [R14] Next three bits must equal the three chip-select strap levels.
// [R15] Control byte low bit high means read, low means write.
// [R16] On match, acknowledge control byte then enter read or write handling.
// [R17] Reduced-pin parts get third select bit as zero; four per bus.
// [R18] Strap inputs stay fixed and settled before any bus operation.
// [R19] Write-protect high blocks writes to the whole array; low allows all.
// [R20] Low supply indication inhibits the internal erase and write.
// [R21] Byte after write control loads the pointer; Stop launches the write cycle.
// [R22] Page writes increment only the low four pointer bits, wrapping in page.
// [R23] Protected writes are still fully acknowledged but change nothing.
// [R24] Reads advance the pointer by one per byte, wrapping to zero.
// [R25] Unmatched control byte: stay released, ignore traffic until next Start.
// [R26] Start or Stop at any bit aborts the byte and resets the state machine.
module eeprom_two_wire_slave_front
    import eeprom_front_pkg::*;
#(
    // Type code that selects this device; the value is arbitrary.
    parameter logic [3:0] DEVICE_CODE = 4'h5,
    // Length of the self-timed write cycle in system clocks; shorten for simulation.
    parameter int WRITE_CYCLES = `WRITE_CYCLE_COUNT
) (
    // System clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Two-wire bus; the serial clock also clocks the bit sampler
    input wire logic scl,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // Chip-select straps
    input wire logic strap_sel_bit0,
    input wire logic strap_sel_bit1,
    input wire logic strap_sel_bit2,
    // Protection inputs
    input wire logic wp,
    input wire logic supply_low,
    // Status
    output logic write_busy,
    output logic bus_idle,
    output logic selected
);
    localparam logic [`WRITE_TIMER_W-1:0] TIMER_LOAD = `WRITE_TIMER_W'(WRITE_CYCLES - 1);

    // Synchronised pins and their previous values.
    pin_in_t pins_raw;
    pin_in_t pins_s;
    logic scl_p_q;
    logic sda_p_q;

    // Serial clock domain bit capture.
    logic bit_val_q;
    logic bit_tgl_q;
    logic tgl_s;
    logic tgl_p_q;

    // Protocol state.
    slave_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    byte_t shift_q, shift_d;
    byte_t tx_q, tx_d;
    byte_t ptr_q, ptr_d;
    logic ack_q, ack_d;
    logic rd_first_q, rd_first_d;
    logic oe_q, oe_d;
    logic pend_q, pend_d;
    logic pg_we;
    logic pg_clr;

    // Storage and write cycle.
    byte_t mem_q [`MEM_DEPTH];
    byte_t page_q [`PAGE_DEPTH];
    logic [`PAGE_DEPTH-1:0] page_vld_q;
    logic busy_q;
    logic [`WRITE_TIMER_W-1:0] timer_q;
    logic sda_o_q;
    logic bus_idle_q;

    assign pins_raw = '{scl: scl, sda: sda_i, sel: {strap_sel_bit2, strap_sel_bit1, strap_sel_bit0},
                        wp: wp, supply_low: supply_low};

    sync_two_flop #(.W($bits(pin_in_t))) u_pin_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(pins_raw),
        .q(pins_s)
    );

    // [R7] Sample on rising clock.
    // The captured bit is held for a whole clock period, far longer than the toggle
    // takes to cross, so the system domain reads it only after the toggle has arrived.
    always_ff @(posedge scl or posedge sys_rst) begin
        if (sys_rst) begin
            bit_val_q <= 1'b0;
            bit_tgl_q <= 1'b0;
        end else begin
            bit_val_q <= sda_i;
            bit_tgl_q <= ~bit_tgl_q;
        end
    end

    sync_two_flop #(.W(1)) u_tgl_sync (
        .clk(clk),
        .sys_rst(sys_rst),
        .d(bit_tgl_q),
        .q(tgl_s)
    );

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
            tgl_p_q <= 1'b0;
        end else begin
            scl_p_q <= pins_s.scl;
            sda_p_q <= pins_s.sda;
            tgl_p_q <= tgl_s;
        end
    end

    // [R5] Start detect.
    wire start_det = pins_s.scl & scl_p_q & sda_p_q & ~pins_s.sda;
    // [R6] Stop detect.
    wire stop_det = pins_s.scl & scl_p_q & ~sda_p_q & pins_s.sda;
    // [R2] Drive changes at clock fall.
    wire scl_fall = scl_p_q & ~pins_s.scl;
    wire bit_evt = tgl_s ^ tgl_p_q;
    // [R4] Idle when both high.
    wire idle_now = pins_s.scl & pins_s.sda;

    wire [7:0] byte_in = {shift_q[6:0], bit_val_q};
    // [R13] Type code compare.
    wire code_ok = byte_in[`CTRL_CODE_MSB:`CTRL_CODE_LSB] == DEVICE_CODE;
    // [R14] Strap compare.
    wire sel_ok = byte_in[`CTRL_SEL_MSB:`CTRL_SEL_LSB] == pins_s.sel;
    // [R15] Direction bit.
    wire rw_read = byte_in[`CTRL_RW_BIT];
    // [R10] Silent while busy.
    wire ctrl_take = code_ok & sel_ok & ~busy_q;
    // [R22] Wrap within page.
    wire [7:0] ptr_page_inc = {ptr_q[7:4], ptr_q[3:0] + 4'h1};
    // [R24] Full wrap on reads.
    wire [7:0] ptr_inc = ptr_q + 8'h01;
    wire byte_done = bit_evt & (cnt_q == `BIT_LAST);
    wire ack_evt = bit_evt & (cnt_q == `ACK_SLOT);
    // [R21] Stop launches write.
    wire launch = stop_det & pend_q & ~busy_q;
    wire cycle_end = busy_q & (timer_q == '0);
    // [R19] Protect gating.
    // [R20] Low supply gating.
    wire commit = cycle_end & ~pins_s.wp & ~pins_s.supply_low;

    always_comb begin
        state_d = state_q;
        cnt_d = cnt_q;
        shift_d = shift_q;
        tx_d = tx_q;
        ptr_d = ptr_q;
        ack_d = ack_q;
        rd_first_d = rd_first_q;
        oe_d = oe_q;
        pend_d = pend_q;
        pg_we = 1'b0;
        pg_clr = 1'b0;
        if (start_det) begin
            // [R26] Start aborts any byte.
            state_d = ST_CTRL;
            cnt_d = 4'h0;
            oe_d = 1'b0;
            ack_d = 1'b0;
            pend_d = 1'b0;
        end else if (stop_det) begin
            // [R26] Stop returns to idle.
            state_d = ST_IDLE;
            cnt_d = 4'h0;
            oe_d = 1'b0;
            ack_d = 1'b0;
            pend_d = 1'b0;
        end else if (state_q != ST_IDLE && state_q != ST_IGNORE) begin
            if (scl_fall) begin
                // [R11] Hold ack through ninth pulse.
                // [R12] Released in master ack slot.
                if (cnt_q == `ACK_SLOT) begin
                    oe_d = ack_q;
                end else begin
                    oe_d = (state_q == ST_RDATA) ? ~tx_q[7] : 1'b0;
                end
            end
            if (bit_evt && cnt_q != `ACK_SLOT) begin
                shift_d = byte_in;
                cnt_d = cnt_q + 4'h1;
                if (state_q == ST_RDATA) begin
                    tx_d = {tx_q[6:0], 1'b1};
                end
            end
            if (byte_done) begin
                // [R9] Acknowledge each byte.
                case (state_q)
                    ST_CTRL: begin
                        // [R16] Select and branch.
                        // [R25] Unmatched goes quiet.
                        ack_d = ctrl_take;
                        rd_first_d = rw_read;
                        state_d = !ctrl_take ? ST_IGNORE : (rw_read ? ST_RDATA : ST_WADDR);
                    end
                    ST_WADDR: begin
                        // [R21] Load address pointer.
                        ptr_d = byte_in;
                        ack_d = 1'b1;
                        pg_clr = 1'b1;
                        state_d = ST_WDATA;
                    end
                    ST_WDATA: begin
                        // [R8] Overwrite oldest slot.
                        // [R23] Ack even when protected.
                        pg_we = 1'b1;
                        ptr_d = ptr_page_inc;
                        ack_d = 1'b1;
                        pend_d = 1'b1;
                    end
                    default: begin
                        ack_d = 1'b0;
                    end
                endcase
            end
            if (ack_evt) begin
                cnt_d = 4'h0;
                if (state_q == ST_RDATA) begin
                    if (rd_first_q || !bit_val_q) begin
                        // [R24] Fetch and advance.
                        tx_d = mem_q[ptr_q];
                        ptr_d = ptr_inc;
                        rd_first_d = 1'b0;
                    end else begin
                        // [R12] Not acked ends read.
                        state_d = ST_IGNORE;
                    end
                end
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            shift_q <= 8'h00;
            tx_q <= 8'hff;
            ptr_q <= 8'h00;
            ack_q <= 1'b0;
            rd_first_q <= 1'b0;
            oe_q <= 1'b0;
            pend_q <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            shift_q <= shift_d;
            tx_q <= tx_d;
            ptr_q <= ptr_d;
            ack_q <= ack_d;
            rd_first_q <= rd_first_d;
            oe_q <= oe_d;
            pend_q <= pend_d;
        end
    end

    // Page buffer is indexed by the low pointer bits, so a seventeenth byte lands on the first.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            page_vld_q <= '0;
        end else if (pg_clr) begin
            page_vld_q <= '0;
        end else if (pg_we) begin
            page_vld_q[ptr_q[3:0]] <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (pg_we) begin
            page_q[ptr_q[3:0]] <= byte_in;
        end
    end

    // The timer runs its full length even when the commit is suppressed.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q <= 1'b0;
            timer_q <= '0;
        end else if (launch) begin
            busy_q <= 1'b1;
            timer_q <= TIMER_LOAD;
        end else if (cycle_end) begin
            busy_q <= 1'b0;
        end else if (busy_q) begin
            timer_q <= timer_q - 1'b1;
        end
    end

    // The array has no reset; its content is undefined until first written.
    always_ff @(posedge clk) begin
        for (int i = 0; i < `PAGE_DEPTH; i++) begin
            if (commit && page_vld_q[i]) begin
                mem_q[{ptr_q[7:4], 4'(i)}] <= page_q[i];
            end
        end
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sda_o_q <= 1'b0;
            bus_idle_q <= 1'b0;
        end else begin
            // [R1] Only ever drive low.
            sda_o_q <= 1'b0;
            bus_idle_q <= idle_now;
        end
    end

    reg selected_q;
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            selected_q <= 1'b0;
        end else begin
            selected_q <= (state_d == ST_WADDR) | (state_d == ST_WDATA) | (state_d == ST_RDATA);
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe = oe_q;
    assign write_busy = busy_q;
    assign bus_idle = bus_idle_q;
    assign selected = selected_q;

endmodule : eeprom_two_wire_slave_front

// File: rtl/sync_two_flop.sv
// Two-flop synchroniser for a bundle of levels.
// Assumes each bit is an independent level; multi-bit values must be quasi-static.
`timescale 1ns/1ns
module sync_two_flop #(
    parameter int W = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_q <= '0;
            q <= '0;
        end else begin
            meta_q <= d;
            q <= meta_q;
        end
    end
endmodule : sync_two_flop

// File: test/eeprom_front_checker.sv
// Concurrent checks on the ports of the two-wire EEPROM slave front end.
// Assumes binding into the design top; every signal is sampled on the system clock.
`timescale 1ns/1ns
module eeprom_front_checker #(
    parameter int WRITE_CYCLES = 100000
) (
    // System clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Two-wire bus
    input wire logic scl,
    input wire logic sda_i,
    input wire logic sda_o,
    input wire logic sda_oe,
    // Status
    input wire logic write_busy,
    input wire logic bus_idle,
    input wire logic selected
);
    int busy_cnt_q;

    default clocking @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    // Length of the current busy stretch, so its end can be measured exactly.
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_cnt_q <= 0;
        end else if (write_busy) begin
            busy_cnt_q <= busy_cnt_q + 1;
        end else begin
            busy_cnt_q <= 0;
        end
    end

    open_drain_a: assert property (sda_oe |-> sda_o == 1'b0)
        else $error("data pin driven high");
    busy_quiet_a: assert property (write_busy |-> !sda_oe)
        else $error("acknowledge during write cycle");
    busy_deselect_a: assert property (write_busy |-> !selected)
        else $error("still selected after stop");
    idle_flag_a: assert property ((scl && sda_i) [*5] |-> bus_idle)
        else $error("idle bus not flagged");
    busy_line_a: assert property ((!scl) [*5] |-> !bus_idle)
        else $error("busy bus flagged idle");
    oe_rise_low_a: assert property ($rose(sda_oe) |-> !scl && $past(!scl, 1))
        else $error("data pulled low while clock high");
    oe_hold_a: assert property (sda_oe && scl |=> sda_oe || !scl)
        else $error("data released during clock high");
    busy_len_a: assert property ($fell(write_busy) |-> busy_cnt_q == WRITE_CYCLES)
        else $error("write cycle length wrong");
    busy_after_stop_a: assert property ($rose(write_busy) |-> scl && sda_i && $past(scl && sda_i, 1))
        else $error("write cycle began without stop");

    cover property ($rose(sda_oe));
    cover property ($fell(write_busy));
    cover property ($rose(selected));
endmodule : eeprom_front_checker

bind eeprom_two_wire_slave_front eeprom_front_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_checker (
    .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .write_busy(write_busy), .bus_idle(bus_idle), .selected(selected));

// File: test/eeprom_two_wire_slave_front_tb.sv
// Self-checking bench for the two-wire EEPROM slave front end.
// Assumes the behavioural master and the checker are compiled alongside.
`timescale 1ns/1ns
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            mismatches++; \
            $display("BAD %s expected %h seen %h", what, exp, got); \
        end \
    end
module eeprom_two_wire_slave_front_tb;
    import eeprom_front_pkg::*;
    localparam logic [3:0] CODE = 4'h6; // Arbitrary type code.
    localparam int WCYC = 400;
    localparam logic [2:0] STRAP = 3'b101;
    logic clk, sys_rst, lk, scl, sda_w, pull_low, sda_o, sda_oe, wp, supply_low, write_busy, bus_idle, selected;
    int mismatches = 0;
    int check_count = 0;
    byte_t mem_exp [256];
    byte_t rd;
    logic ack;

    // The wire is pulled up unless either party pulls it low.
    assign sda_w = !((sda_oe && !sda_o) || pull_low);

    two_wire_master m (.lk(lk), .sda_w(sda_w), .scl(scl), .pull_low(pull_low));

    eeprom_two_wire_slave_front #(.DEVICE_CODE(CODE), .WRITE_CYCLES(WCYC)) u_dut (
        .clk(clk), .sys_rst(sys_rst), .scl(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe(sda_oe),
        .strap_sel_bit0(STRAP[0]), .strap_sel_bit1(STRAP[1]), .strap_sel_bit2(STRAP[2]),
        .wp(wp), .supply_low(supply_low), .write_busy(write_busy), .bus_idle(bus_idle), .selected(selected));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        lk = 1'b0;
        #7;
        forever #16 lk = ~lk;
    end

    task automatic ctrl(input logic [3:0] code, input logic [2:0] sel, input logic rd_n, input logic exp_ack);
        m.start_cond();
        m.xbyte({code, sel, rd_n}, 1'b1, rd, ack);
        `CHK("control ack", exp_ack, ack)
    endtask : ctrl

    task automatic send(input byte_t d);
        m.xbyte(d, 1'b1, rd, ack);
        `CHK("byte ack", 1'b0, ack)
    endtask : send

    task automatic finish_write();
        int n;
        n = 0;
        while (write_busy !== 1'b1 && n < 40) begin
            @(posedge clk);
            n++;
        end
        `CHK("busy start", 1'b1, write_busy)
        ctrl(CODE, STRAP, 1'b0, 1'b1);
        m.stop_cond();
        n = 0;
        while (write_busy !== 1'b0 && n < WCYC + 40) begin
            @(posedge clk);
            n++;
        end
        `CHK("busy end", 1'b0, write_busy)
    endtask : finish_write

    task automatic write_bytes(input byte_t addr, input int n, input byte_t first, input logic commit);
        byte_t a;
        a = addr;
        ctrl(CODE, STRAP, 1'b0, 1'b0);
        send(addr);
        for (int i = 0; i < n; i++) begin
            send(first + byte_t'(i));
            // later bytes overwrite within the page
            if (commit) begin
                mem_exp[a] = first + byte_t'(i);
            end
            a[3:0] = a[3:0] + 4'h1;
        end
        m.stop_cond();
        finish_write();
    endtask : write_bytes

    task automatic read_bytes(input byte_t addr, input int n);
        ctrl(CODE, STRAP, 1'b0, 1'b0);
        send(addr);
        ctrl(CODE, STRAP, 1'b1, 1'b0);
        for (int i = 0; i < n; i++) begin
            m.xbyte(8'hff, (i == n - 1), rd, ack);
            `CHK("read data", mem_exp[addr + byte_t'(i)], rd)
        end
        m.stop_cond();
    endtask : read_bytes

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : wrap_up

    initial begin
        #3000000;
        mismatches++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        wp = 1'b0;
        supply_low = 1'b0;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (10) @(posedge clk);
        `CHK("idle flag", 1'b1, bus_idle)
        ctrl(CODE ^ 4'h1, STRAP, 1'b0, 1'b1);
        m.xbyte(8'h00, 1'b1, rd, ack);
        `CHK("ignored byte", 1'b1, ack)
        m.stop_cond();
        for (int b = 0; b < 3; b++) begin
            ctrl(CODE, STRAP ^ (3'b001 << b), 1'b1, 1'b1);
            m.stop_cond();
        end
        // stop in mid-byte, the next command must still be taken
        m.start_cond();
        for (int i = 0; i < 4; i++) begin
            m.xbit(CODE[3 - i], ack);
        end
        m.stop_cond();
        write_bytes(8'h3e, 18, 8'h40, 1'b1);
        read_bytes(8'h30, 16);
        write_bytes(8'hff, 1, 8'ha5, 1'b1);
        write_bytes(8'h00, 1, 8'h5a, 1'b1);
        m.half_ticks = 30;
        read_bytes(8'hff, 2);
        m.half_ticks = 13;
        // blocked writes are acknowledged yet change nothing
        for (int p = 0; p < 2; p++) begin
            @(posedge clk);
            wp <= (p == 0);
            supply_low <= (p == 1);
            write_bytes(8'h31, 1, 8'hee, 1'b0);
            @(posedge clk);
            wp <= 1'b0;
            supply_low <= 1'b0;
            read_bytes(8'h31, 1);
        end
        wrap_up();
    end
endmodule : eeprom_two_wire_slave_front_tb

// File: test/two_wire_master.sv
// Behavioural two-wire bus master with its own link clock.
// Assumes the bench models the pull-up; the serial clock stands high between frames.
`timescale 1ns/1ns
module two_wire_master
    import eeprom_front_pkg::*;
(
    // Link clock
    input wire logic lk,
    // Bus
    input wire logic sda_w,
    output logic scl,
    output logic pull_low
);
    // Link ticks per clock phase; raise it to act as a slow master.
    int half_ticks = 13;

    initial begin
        scl = 1'b1;
        pull_low = 1'b0;
    end

    task automatic wait_ticks(input int n);
        repeat (n) @(posedge lk);
    endtask : wait_ticks

    task automatic start_cond();
        pull_low <= 1'b0;
        wait_ticks(10);
        scl <= 1'b1;
        wait_ticks(half_ticks);
        pull_low <= 1'b1;
        wait_ticks(half_ticks);
        scl <= 1'b0;
    endtask : start_cond

    task automatic stop_cond();
        wait_ticks(4);
        pull_low <= 1'b1;
        wait_ticks(half_ticks);
        scl <= 1'b1;
        wait_ticks(half_ticks);
        pull_low <= 1'b0;
        wait_ticks(half_ticks);
    endtask : stop_cond

    task automatic xbit(input logic b, output logic r);
        wait_ticks(4);
        pull_low <= ~b;
        wait_ticks(half_ticks);
        scl <= 1'b1;
        wait_ticks(half_ticks);
        r = sda_w;
        scl <= 1'b0;
    endtask : xbit

    task automatic xbyte(input byte_t d, input logic ack_in, output byte_t r, output logic ack_out);
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r[i]);
        end
        xbit(ack_in, ack_out);
    endtask : xbyte
endmodule : two_wire_master
